// [mlfr_asserts.sv]
// Concurrent checks on the ports of the lock fault response block.
`timescale 1ns/10ps
`default_nettype none
module mlfr_asserts
  import mlfr_pkg::*;
(
  input wire logic           mclk,
  input wire logic           rst_b,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic [31:0]    avs_readdata,
  input wire logic           avs_waitrequest,
  input wire logic           pos_timeout_in,
  input wire logic           pos_rate_in,
  input wire logic           current_sat_in,
  input wire logic           speed_sat_in,
  input wire mlfr_gate_cmd_t gate_cmd,
  input wire logic           fault_indicator_pin_n,
  input wire logic           pos_timeout_fault,
  input wire logic           pos_rate_fault,
  input wire logic           current_sat_flag,
  input wire logic           speed_sat_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_tmo_gated: assert property (pos_timeout_fault |-> $past(pos_timeout_in, 3))
    else $error("timeout fault without its input");
  a_rate_gated: assert property (pos_rate_fault |-> $past(pos_rate_in, 3))
    else $error("rate fault without its input");
  a_cur_gated: assert property (current_sat_flag |-> $past(current_sat_in, 3))
    else $error("current flag without its input");
  a_spd_gated: assert property (speed_sat_flag |-> $past(speed_sat_in, 3))
    else $error("speed flag without its input");
  a_drive_pin: assert property (gate_cmd.drive != MLFR_DRV_RUN |-> !fault_indicator_pin_n)
    else $error("driver action without fault pin");
  a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in first cycle");
  a_wait_second: assert property ((avs_read | avs_write) && avs_waitrequest ##1
    (avs_read | avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high in second cycle");
  a_rdata_hold: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule
bind mlfr_top mlfr_asserts u_chk (.mclk(mclk), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pos_timeout_in(pos_timeout_in),
  .pos_rate_in(pos_rate_in), .current_sat_in(current_sat_in),
  .speed_sat_in(speed_sat_in), .gate_cmd(gate_cmd),
  .fault_indicator_pin_n(fault_indicator_pin_n),
  .pos_timeout_fault(pos_timeout_fault), .pos_rate_fault(pos_rate_fault),
  .current_sat_flag(current_sat_flag), .speed_sat_flag(speed_sat_flag));
`default_nettype wire

// [mlfr_map.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef MLFR_MAP_SVH
`define MLFR_MAP_SVH
`define MLFR_OFS_CONFIG      4'h0
`define MLFR_OFS_RETRY_LIM   4'h1
`define MLFR_OFS_CONTROL     4'h2
`define MLFR_OFS_STATUS      4'h3
`define MLFR_OFS_IRQ_STATUS  4'h4
`define MLFR_OFS_IRQ_MASK    4'h5
`define MLFR_CFG_RETRY_HI    10
`define MLFR_CFG_RETRY_LO    7
`define MLFR_CFG_MODE_HI     6
`define MLFR_CFG_MODE_LO     3
`define MLFR_CFG_TMO_EN      2
`define MLFR_CFG_RATE_EN     1
`define MLFR_CFG_SAT_EN      0
`define MLFR_CFG_RESET       32'h0000_0000
`define MLFR_RETRY_LIM_RESET 3'h0
`define MLFR_CLK_MHZ         250
`define MLFR_HALF_S_MS       500
`define MLFR_HALF_S_CYC      (`MLFR_HALF_S_MS * 1000 * `MLFR_CLK_MHZ)
`endif

// [mlfr_motor_model.sv]
// Power stage model that reports a stalled rotor as a lock.
`timescale 1ns/10ps
`default_nettype none
module mlfr_motor_model
  import mlfr_pkg::*;
(
  input  wire mlfr_gate_cmd_t gate_cmd,
  input  wire logic           stall,
  output logic                lock_detect
);
  // A stalled rotor only shows as a lock while the bridge is switching.
  assign lock_detect = stall && (gate_cmd.drive == MLFR_DRV_RUN);
endmodule
`default_nettype wire

// [mlfr_pkg.sv]
// Types shared by the motor lock fault response logic.
package mlfr_pkg;
  typedef enum logic [1:0] {
    MLFR_DRV_RUN,
    MLFR_DRV_TRISTATE,
    MLFR_DRV_RECIRC,
    MLFR_DRV_BRAKE
  } mlfr_drive_t;
  typedef struct packed {
    mlfr_drive_t drive;
    logic        brake_high;
  } mlfr_gate_cmd_t;
  typedef struct packed {
    logic lock;
    logic pos_timeout;
    logic pos_rate;
    logic current_sat;
    logic speed_sat;
  } mlfr_events_t;
endpackage

// [mlfr_top.sv]
// Motor lock fault response selection with its register slave.
`timescale 1ns/10ps
`include "mlfr_map.svh"
`default_nettype none
module mlfr_top
  import mlfr_pkg::*;
#(
  parameter int unsigned HALF_S_CYC = `MLFR_HALF_S_CYC
) (
  input  wire logic           mclk,
  input  wire logic           rst_b,
  input  wire logic [3:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  output logic      [31:0]    avs_readdata,
  output logic                avs_waitrequest,
  input  wire logic           lock_detect_in,
  input  wire logic           pos_timeout_in,
  input  wire logic           pos_rate_in,
  input  wire logic           current_sat_in,
  input  wire logic           speed_sat_in,
  output mlfr_gate_cmd_t      gate_cmd,
  output logic                fault_indicator_pin_n,
  output logic                pos_timeout_fault,
  output logic                pos_rate_fault,
  output logic                current_sat_flag,
  output logic                speed_sat_flag,
  output logic                irq
);

  mlfr_events_t    ev_meta;
  mlfr_events_t    ev_sync;
  logic [31:0]     cfg;
  logic [2:0]      retry_count_limit;
  logic [4:0]      irq_status;
  logic [4:0]      irq_mask;
  logic            lock_latched;
  logic            lock_active;
  logic            retry_wait;
  logic [3:0]      retry_used;
  logic [31:0]     delay_cnt;
  logic [31:0]     next_delay_target;
  logic            sw_clear;
  logic            bus_done;
  logic            bus_wr;
  logic [3:0]      held_mode;
  logic [4:0]      status_set;
  logic            status_clr;
  logic [3:0]      lock_response_select;
  logic [3:0]      lock_retry_delay;
  logic            lock_event;
  logic            ev_lock_q;
  mlfr_gate_cmd_t  next_gate;
  logic            next_pin_n;

  assign lock_response_select = cfg[`MLFR_CFG_MODE_HI:`MLFR_CFG_MODE_LO];
  assign lock_retry_delay     = cfg[`MLFR_CFG_RETRY_HI:`MLFR_CFG_RETRY_LO];

  // Returns the driver state that a lock code calls for.
  function automatic mlfr_gate_cmd_t mode_gate(input logic [3:0] m);
    mlfr_gate_cmd_t g;
    g = '{drive: MLFR_DRV_RUN, brake_high: 1'b0};
    case (m)
      4'h0, 4'h4: g.drive = MLFR_DRV_TRISTATE;
      4'h1, 4'h5: g.drive = MLFR_DRV_RECIRC;
      4'h2, 4'h6: g = '{drive: MLFR_DRV_BRAKE, brake_high: 1'b1};
      4'h3, 4'h7: g = '{drive: MLFR_DRV_BRAKE, brake_high: 1'b0};
      default:    g.drive = MLFR_DRV_RUN;
    endcase
    return g;
  endfunction

  // Tells whether a lock code uses automatic retry.
  function automatic logic mode_retry(input logic [3:0] m);
    return (m >= 4'h4) && (m <= 4'h7);
  endfunction

  // Tells whether a lock code only reports and leaves the driver alone.
  function automatic logic mode_report(input logic [3:0] m);
    return m == 4'h8;
  endfunction

  // Tells whether a lock code switches lock detection off.
  function automatic logic mode_off(input logic [3:0] m);
    return m > 4'h8;
  endfunction

  // Tells whether a completed write targets the given register.
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [3:0] adr,
                                   input logic [3:0] ofs);
    return strobe && (adr == ofs);
  endfunction

  // Two-stage synchroniser for the external event levels.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ev_meta <= '0;
      ev_sync <= '0;
    end else begin
      ev_meta <= '{lock_detect_in, pos_timeout_in, pos_rate_in,
                   current_sat_in, speed_sat_in};
      ev_sync <= ev_meta;
    end
  end

  // Rising edge of a lock detection, ignored while detection is disabled.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ev_lock_q <= 1'b0;
    end else begin
      ev_lock_q <= ev_sync.lock;
    end
  end
  assign lock_event = ev_sync.lock && !ev_lock_q &&
                      !mode_off(lock_response_select);

  // Response code captured when a fault starts; a later rewrite of the
  // configuration keeps the action of a pending fault, except that a code
  // above 8 switches detection off and ends the fault.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      held_mode <= 4'h0;
    end else if (lock_event && !lock_active) begin
      held_mode <= lock_response_select;
    end
  end

  // Retry delay in cycles: 0h and 1h are one half second, code n above 1 is n-1 seconds.
  always_comb begin
    if (lock_retry_delay <= 4'h1) begin
      next_delay_target = HALF_S_CYC;
    end else begin
      next_delay_target = 32'(HALF_S_CYC * 2 *
                              (32'(lock_retry_delay) - 32'd1));
    end
  end

  // Lock fault sequencing: latch, retry wait and retry counting.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lock_active  <= 1'b0;
      lock_latched <= 1'b0;
      retry_wait   <= 1'b0;
      retry_used   <= 4'h0;
      delay_cnt    <= 32'h0000_0000;
    end else if (sw_clear) begin
      lock_active  <= 1'b0;
      lock_latched <= 1'b0;
      retry_wait   <= 1'b0;
      retry_used   <= 4'h0;
      delay_cnt    <= 32'h0000_0000;
    end else if (mode_off(lock_response_select)) begin
      lock_active  <= 1'b0;
      lock_latched <= 1'b0;
      retry_wait   <= 1'b0;
    end else if (lock_event && !lock_active) begin
      lock_active <= 1'b1;
      if (mode_retry(lock_response_select) &&
          retry_used < {1'b0, retry_count_limit}) begin
        retry_wait <= 1'b1;
        delay_cnt  <= 32'h0000_0000;
      end else if (!mode_report(lock_response_select)) begin
        lock_latched <= 1'b1;
      end
    end else if (retry_wait) begin
      if (delay_cnt + 32'd1 >= next_delay_target) begin
        retry_wait  <= 1'b0;
        lock_active <= 1'b0;
        retry_used  <= retry_used + 4'h1;
      end else begin
        delay_cnt <= delay_cnt + 32'd1;
      end
    end else if (lock_active && mode_report(held_mode) &&
                 !ev_sync.lock) begin
      lock_active <= 1'b0;
    end
  end

  // Driver command and fault pin chosen from the current lock state.
  always_comb begin
    next_gate  = '{drive: MLFR_DRV_RUN, brake_high: 1'b0};
    next_pin_n = 1'b1;
    if (lock_active) begin
      next_pin_n = 1'b0;
      if (!mode_report(held_mode)) begin
        next_gate = mode_gate(held_mode);
      end
    end
  end

  // Registered driver command and fault pin.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gate_cmd              <= '{drive: MLFR_DRV_RUN, brake_high: 1'b0};
      fault_indicator_pin_n <= 1'b1;
    end else begin
      gate_cmd              <= next_gate;
      fault_indicator_pin_n <= next_pin_n;
    end
  end

  // Registered indicator flags, each gated by its enable bit.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pos_timeout_fault <= 1'b0;
      pos_rate_fault    <= 1'b0;
      current_sat_flag  <= 1'b0;
      speed_sat_flag    <= 1'b0;
    end else begin
      pos_timeout_fault <= ev_sync.pos_timeout && cfg[`MLFR_CFG_TMO_EN];
      pos_rate_fault    <= ev_sync.pos_rate && cfg[`MLFR_CFG_RATE_EN];
      current_sat_flag  <= ev_sync.current_sat && cfg[`MLFR_CFG_SAT_EN];
      speed_sat_flag    <= ev_sync.speed_sat && cfg[`MLFR_CFG_SAT_EN];
    end
  end

  // Interrupt level, high while an unmasked sticky bit is set.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Avalon slave answers every access one cycle after it is presented.
  // Waitrequest idles high, so it comes from a flop and drops for the
  // single answering cycle.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end
  assign bus_done = !avs_waitrequest;
  assign bus_wr   = avs_write && bus_done;
  assign sw_clear = reg_hit(bus_wr, avs_address, `MLFR_OFS_CONTROL) &&
                    avs_writedata[0];

  // Configuration and mask registers.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg               <= `MLFR_CFG_RESET;
      retry_count_limit <= `MLFR_RETRY_LIM_RESET;
      irq_mask          <= 5'h00;
    end else if (bus_wr) begin
      case (avs_address)
        `MLFR_OFS_CONFIG:    cfg <= {21'h000000, avs_writedata[10:0]};
        `MLFR_OFS_RETRY_LIM: retry_count_limit <= avs_writedata[2:0];
        `MLFR_OFS_IRQ_MASK:  irq_mask <= avs_writedata[4:0];
        default:             cfg <= cfg;
      endcase
    end
  end

  // Events that set the sticky bits, and the clear strobe for them.
  assign status_set = {lock_event, !next_pin_n && lock_latched,
                       pos_timeout_fault, pos_rate_fault,
                       current_sat_flag || speed_sat_flag};
  assign status_clr = reg_hit(bus_wr, avs_address, `MLFR_OFS_IRQ_STATUS);

  // One sticky bit per event; a set in the same cycle as a
  // write-one-to-clear wins, so no event is lost.
  for (genvar i = 0; i < 5; i++) begin : g_sticky
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        irq_status[i] <= 1'b0;
      end else if (status_set[i]) begin
        irq_status[i] <= 1'b1;
      end else if (status_clr && avs_writedata[i]) begin
        irq_status[i] <= 1'b0;
      end
    end
  end

  // Read data, registered; unmapped addresses read zero.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_done) begin
      case (avs_address)
        `MLFR_OFS_CONFIG:     avs_readdata <= cfg;
        `MLFR_OFS_RETRY_LIM:  avs_readdata <= {29'h0, retry_count_limit};
        `MLFR_OFS_STATUS:     avs_readdata <= {24'h0, retry_used,
                                               retry_wait, lock_latched,
                                               lock_active, !next_pin_n};
        `MLFR_OFS_IRQ_STATUS: avs_readdata <= {27'h0, irq_status};
        `MLFR_OFS_IRQ_MASK:   avs_readdata <= {27'h0, irq_mask};
        default:              avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the motor lock fault response block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mlfr_pkg::*;
  localparam int H = 10;
  logic           mclk = 1'b0;
  logic           rst_b = 1'b0;
  logic [3:0]     adr = 4'h0;
  logic           rd_en = 1'b0;
  logic           wr_en = 1'b0;
  logic [31:0]    wdat = 32'h0;
  logic [31:0]    rdat;
  logic           wreq;
  logic           stall = 1'b0;
  logic           lock;
  logic [3:0]     ev = 4'h0;
  logic [3:0]     flg;
  mlfr_gate_cmd_t gc;
  logic           pin_n;
  logic           irq;
  logic [31:0]    cfg;
  logic [31:0]    expq[$];
  int             mismatches = 0;
  int             check_count = 0;
  int             n;
  int             d;
  int             c;
  always #2 mclk = ~mclk;
  mlfr_top #(.HALF_S_CYC(H)) dut (.mclk(mclk), .rst_b(rst_b),
    .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .lock_detect_in(lock), .pos_timeout_in(ev[3]), .pos_rate_in(ev[2]),
    .current_sat_in(ev[1]), .speed_sat_in(ev[0]), .gate_cmd(gc),
    .fault_indicator_pin_n(pin_n), .pos_timeout_fault(flg[3]),
    .pos_rate_fault(flg[2]), .current_sat_flag(flg[1]),
    .speed_sat_flag(flg[0]), .irq(irq));
  mlfr_motor_model motor (.gate_cmd(gc), .stall(stall), .lock_detect(lock));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    adr <= a;
    wdat <= v;
    wr_en <= w;
    rd_en <= !w;
    do @(posedge mclk); while (wreq !== 1'b0);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_pin(input logic v);
    n = 0;
    while (pin_n !== v && n < 400) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic stop_test;
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk)
    if (rd_en && wreq === 1'b0)
      chk(rdat, expq.pop_front());
  initial begin
    #40000;
    mismatches++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h1d69ef7f));
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(4'h0, 32'h0);
    rd(4'hF, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(4'h0, 32'(m) << 3);
      stall <= 1'b1;
      wait_pin(1'b0);
      stall <= 1'b0;
      repeat (30) @(posedge mclk);
      chk(32'(pin_n), 32'h0);
      chk(32'(gc.drive), m[1] ? 32'h3 : (m[0] ? 32'h2 : 32'h1));
      if (m[1]) chk(32'(gc.brake_high), 32'(!m[0]));
      wr(4'h2, 32'h1);
      repeat (3) @(posedge mclk);
      chk(32'(pin_n), 32'h1);
    end
    wr(4'h1, 32'h1);
    for (int m = 4; m < 8; m++) begin
      c = m[0] ? 3 : 1;
      d = (c == 1) ? H : 2 * H * (c - 1);
      wr(4'h0, (32'(c) << 7) | (32'(m) << 3));
      stall <= 1'b1;
      wait_pin(1'b0);
      chk(32'(gc.drive), m[1] ? 32'h3 : (m[0] ? 32'h2 : 32'h1));
      wait_pin(1'b1);
      chk(32'(n >= d - 2 && n <= d + 6), 32'h1);
      wait_pin(1'b0);
      repeat (4 * d) @(posedge mclk);
      chk(32'(pin_n), 32'h0);
      chk(32'(gc.drive), m[1] ? 32'h3 : (m[0] ? 32'h2 : 32'h1));
      stall <= 1'b0;
      wr(4'h2, 32'h1);
    end
    for (int m = 8; m < 16; m++) begin
      wr(4'h0, 32'(m) << 3);
      stall <= 1'b1;
      repeat (10) @(posedge mclk);
      chk(32'(pin_n), 32'(m > 8));
      chk(32'(gc.drive), 32'h0);
      stall <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(32'(pin_n), 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      cfg = ($urandom() & 32'h7) | 32'h48;
      wr(4'h0, cfg);
      rd(4'h0, cfg);
      ev <= 4'hF;
      repeat (6) @(posedge mclk);
      chk(32'(flg), 32'({cfg[2], cfg[1], cfg[0], cfg[0]}));
      ev <= 4'h0;
      repeat (6) @(posedge mclk);
      chk(32'(flg), 32'h0);
    end
    wr(4'h0, 32'h49);
    wr(4'h4, 32'h1F);
    ev <= 4'h3;
    repeat (6) @(posedge mclk);
    chk(32'(irq), 32'h0);
    rd(4'h4, 32'h1);
    wr(4'h5, 32'h1);
    ev <= 4'h0;
    repeat (6) @(posedge mclk);
    chk(32'(irq), 32'h1);
    wr(4'h4, 32'h1);
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
